/* File: pioxb_pkg.sv */
// Port I/O crossbar constants
package pioxb_pkg;

    // SFR addresses
    localparam logic [7:0] PORT0_DATA_ADDR  = 8'h80;
    localparam logic [7:0] PORT1_DATA_ADDR  = 8'h90;
    localparam logic [7:0] PORT2_DATA_ADDR  = 8'hA0;
    localparam logic [7:0] PORT3_DATA_ADDR  = 8'hB0;
    localparam logic [7:0] PORT4_DATA_ADDR  = 8'hC7;
    localparam logic [7:0] PORT0_SKIP_ADDR  = 8'hD4;
    localparam logic [7:0] PORT1_SKIP_ADDR  = 8'hD5;
    localparam logic [7:0] PORT2_SKIP_ADDR  = 8'hD6;
    localparam logic [7:0] PORT3_SKIP_ADDR  = 8'hD7;
    localparam logic [7:0] IN_MODE_BASE     = 8'hF1;
    localparam logic [7:0] OUT_MODE_BASE    = 8'hA4;
    localparam logic [7:0] ROUTE0_ADDR      = 8'hE1;
    localparam logic [7:0] ROUTE1_ADDR      = 8'hE2;
    localparam logic [7:0] ROUTE2_ADDR      = 8'hE3;
    localparam logic [7:0] ROUTE3_ADDR      = 8'hC6;

    // Field positions in the third routing select register
    localparam int XBAR_EN_POS   = 6;
    localparam int WEAK_PUD_POS  = 7;

    // Reset values
    localparam logic [7:0] DATA_RST      = 8'hFF;
    localparam logic [7:0] SKIP_RST      = 8'h00;
    localparam logic [7:0] IN_MODE_RST   = 8'hFF;
    localparam logic [7:0] OUT_MODE_RST  = 8'h00;
    localparam logic [7:0] ROUTE_RST     = 8'h00;

    // Geometry
    localparam int NPORT       = 5;
    localparam int NXPIN       = 32;
    localparam int NFUNC       = 8;
    localparam int PIN_IDX_W   = 6;

    // Function slots; slots 0 and 1 are the SMBus data and clock
    localparam int FN_SDA      = 0;
    localparam int FN_SCL      = 1;

endpackage

/* File: pioxb_prio.sv */
// Priority crossbar decoder: assigns functions to free pins
`timescale 1ns/1ps
module pioxb_prio
    import pioxb_pkg::*;
(
    input  wire logic [NFUNC-1:0]     fn_en_i,   // Enabled functions
    input  wire logic [NXPIN-1:0]     skip_i,    // Skipped pins
    output logic      [NXPIN-1:0]     own_o,     // Pin owned by a function
    output logic      [NXPIN*3-1:0]   fn_sel_o   // Owning function per pin
);

    always_comb begin
        logic [NXPIN-1:0] taken;
        logic             done;
        done     = 1'b0;
        taken    = skip_i;
        own_o    = '0;
        fn_sel_o = '0;
        for (int f = 0; f < NFUNC; f++) begin
            done = 1'b0;
            for (int p = 0; p < NXPIN; p++) begin
                if (fn_en_i[f] && !done && !taken[p]) begin
                    taken[p]            = 1'b1;
                    own_o[p]            = 1'b1;
                    fn_sel_o[p*3 +: 3]  = 3'(f);
                    done                = 1'b1;
                end
            end
        end
    end

endmodule

/* File: pioxb_top.sv */
// Port I/O block with data latches, modes, pull-ups and crossbar
`timescale 1ns/1ps
// What this block does
// - Port data reads return pin levels regardless of routing.
// - Port 4 is digital only and never routed by the crossbar.
// - Each pin's output mode bit selects open-drain or push-pull.
// - Analog pins lose pull-up, output driver and input receiver.
// - Input mode bit 1 is digital, 0 analog; reset digital.
// - SMBus data and clock pins always drive open-drain.
// - Pull-up disable low enables pull-ups on open-drain pins.
// - Pull-up is off on any pin actively driving low.
// - Routing works only after crossbar enable is written to 1.
// - All output drivers are off while crossbar is disabled.
// - A data register write is held in the output latch.
// - Read-modify-write accesses read the latch, not the pins.
// - Data registers are bit and byte addressable, port 4 byte only.
// - Ports 0 to 3 have skip registers; 1 skips; reset 0.
// - Enabled functions go to pins by a fixed priority decoder.
// - Data bit 0 drives low, 1 high; latches reset to ones.
module pioxb_top
    import pioxb_pkg::*;
(
    input  wire logic                 core_clk_i,   // System clock
    input  wire logic                 reset_n_i,    // Sync reset, low
    input  wire logic                 sfr_wr_i,     // SFR write strobe
    input  wire logic                 sfr_rd_i,     // SFR read strobe
    input  wire logic                 sfr_bit_i,    // Bit access
    input  wire logic                 sfr_rmw_i,    // Read-modify-write
    input  wire logic [7:0]           sfr_addr_i,   // SFR address
    input  wire logic [2:0]           sfr_bitsel_i, // Bit number
    input  wire logic [7:0]           sfr_wdata_i,  // Write data
    output logic      [7:0]           sfr_rdata_o,  // Read data
    output logic                      sfr_hit_o,    // Address decoded
    input  wire logic [NFUNC-1:0]     fn_out_i,     // Peripheral outputs
    output logic      [NFUNC-1:0]     fn_in_o,      // Peripheral inputs
    input  wire logic [NPORT*8-1:0]   pin_i,        // Pin levels
    output logic      [NPORT*8-1:0]   pin_o,        // Pin drive value
    output logic      [NPORT*8-1:0]   pin_oe_o,     // Pin driver on
    output logic      [NPORT*8-1:0]   pull_en_o,    // Weak pull-up on
    output logic      [NPORT*8-1:0]   dig_in_en_o   // Digital receiver on
);

    ////////////////////////////////////////////////////////////////////
    // Registers

    localparam int NPIN = NPORT * 8;

    logic [7:0]        data_ff   [NPORT];
    logic [7:0]        skip_ff   [NPORT-1];
    logic [7:0]        inmode_ff [NPORT-1];
    logic [7:0]        outmode_ff[NPORT];
    logic [7:0]        route_ff  [4];
    logic [NPIN-1:0]   sync1_ff;
    logic [NPIN-1:0]   sync2_ff;
    logic [NPIN-1:0]   sync3_ff;
    logic [NPIN-1:0]   pin_lvl_ff;

    // Byte or bit merge of write data into a register
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic       bitacc,
                                         input logic [2:0] sel,
                                         input logic [7:0] wd);
        logic [7:0] r;
        r = old;
        if (bitacc) begin
            r[sel] = wd[0];
        end else begin
            r = wd;
        end
        return r;
    endfunction

    // Address range check; returns 1 on hit
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] base,
                                      input int         n);
        return (a >= base) && (a < base + 8'(n));
    endfunction

    logic xbar_en;
    logic weak_pud;
    assign xbar_en  = route_ff[2][XBAR_EN_POS];
    assign weak_pud = route_ff[2][WEAK_PUD_POS];

    logic [7:0] data_addr [NPORT];
    logic [7:0] skip_addr [NPORT-1];
    assign data_addr[0] = PORT0_DATA_ADDR;
    assign data_addr[1] = PORT1_DATA_ADDR;
    assign data_addr[2] = PORT2_DATA_ADDR;
    assign data_addr[3] = PORT3_DATA_ADDR;
    assign data_addr[4] = PORT4_DATA_ADDR;
    assign skip_addr[0] = PORT0_SKIP_ADDR;
    assign skip_addr[1] = PORT1_SKIP_ADDR;
    assign skip_addr[2] = PORT2_SKIP_ADDR;
    assign skip_addr[3] = PORT3_SKIP_ADDR;

    ////////////////////////////////////////////////////////////////////
    // Data latches

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NPORT; p++) begin
                data_ff[p] <= DATA_RST;
            end
        end else if (sfr_wr_i) begin
            for (int p = 0; p < NPORT; p++) begin
                if (sfr_addr_i == data_addr[p]) begin
                    if (p == NPORT - 1 && sfr_bit_i) begin
                        data_ff[p] <= data_ff[p];
                    end else begin
                        data_ff[p] <= merge(data_ff[p], sfr_bit_i,
                                            sfr_bitsel_i,
                                            sfr_wdata_i);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NPORT - 1; p++) begin
                skip_ff[p]   <= SKIP_RST;
                inmode_ff[p] <= IN_MODE_RST;
            end
        end else if (sfr_wr_i && !sfr_bit_i) begin
            for (int p = 0; p < NPORT - 1; p++) begin
                if (sfr_addr_i == skip_addr[p]) begin
                    skip_ff[p] <= sfr_wdata_i;
                end
                if (sfr_addr_i == IN_MODE_BASE + 8'(p)) begin
                    inmode_ff[p] <= sfr_wdata_i;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NPORT; p++) begin
                outmode_ff[p] <= OUT_MODE_RST;
            end
            for (int r = 0; r < 4; r++) begin
                route_ff[r] <= ROUTE_RST;
            end
        end else if (sfr_wr_i && !sfr_bit_i) begin
            for (int p = 0; p < NPORT; p++) begin
                if (sfr_addr_i == OUT_MODE_BASE + 8'(p)) begin
                    outmode_ff[p] <= sfr_wdata_i;
                end
            end
            if (sfr_addr_i == ROUTE0_ADDR) route_ff[0] <= sfr_wdata_i;
            if (sfr_addr_i == ROUTE1_ADDR) route_ff[1] <= sfr_wdata_i;
            if (sfr_addr_i == ROUTE2_ADDR) route_ff[2] <= sfr_wdata_i;
            if (sfr_addr_i == ROUTE3_ADDR) route_ff[3] <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin input synchroniser

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sync1_ff   <= '0;
            sync2_ff   <= '0;
            sync3_ff   <= '0;
            pin_lvl_ff <= '0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NPIN; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_lvl_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Crossbar

    logic [NXPIN-1:0]   skip_vec;
    logic [NXPIN-1:0]   own;
    logic [NXPIN*3-1:0] fn_sel;
    logic [NFUNC-1:0]   fn_en;
    logic [NPIN-1:0]    analog;
    logic [NPIN-1:0]    latch_vec;
    logic [NPIN-1:0]    pp_vec;
    logic [NPIN-1:0]    own_all;
    logic [NPIN*3-1:0]  sel_all;

    always_comb begin
        for (int p = 0; p < NPORT - 1; p++) begin
            skip_vec[p*8 +: 8] = skip_ff[p];
            analog[p*8 +: 8]   = ~inmode_ff[p];
        end
        analog[NPIN-1 -: 8] = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            latch_vec[p*8 +: 8] = data_ff[p];
            pp_vec[p*8 +: 8]    = outmode_ff[p];
        end
    end

    assign fn_en = xbar_en ? route_ff[0] : '0;

    pioxb_prio u_prio (
        .fn_en_i  (fn_en),
        .skip_i   (skip_vec),
        .own_o    (own),
        .fn_sel_o (fn_sel)
    );

    assign own_all = {8'h00, own};
    assign sel_all = {24'h000000, fn_sel};

    ////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic [NPIN-1:0] nxt_pin;
    logic [NPIN-1:0] nxt_oe;
    logic [NPIN-1:0] nxt_pull;
    logic [NFUNC-1:0] nxt_fn_in;

    always_comb begin
        logic [2:0] f;
        logic       val;
        logic       od;
        f         = 3'h0;
        val       = 1'b0;
        od        = 1'b0;
        nxt_fn_in = '1;
        for (int i = 0; i < NPIN; i++) begin
            f   = 3'h0;
            val = latch_vec[i];
            od  = !pp_vec[i];
            if (own_all[i]) begin
                f   = sel_all[i*3 +: 3];
                val = fn_out_i[f];
                if (int'(f) == FN_SDA || int'(f) == FN_SCL) begin
                    od = 1'b1;
                end
                nxt_fn_in[f] = pin_lvl_ff[i];
            end
            nxt_pin[i] = val;
            nxt_oe[i]  = xbar_en && !analog[i]
                         && (!od || !val);
            nxt_pull[i] = !analog[i] && !weak_pud && od
                          && !(nxt_oe[i] && !val);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pin_o       <= '1;
            pin_oe_o    <= '0;
            pull_en_o   <= '1;
            dig_in_en_o <= '1;
            fn_in_o     <= '1;
        end else begin
            pin_o       <= nxt_pin;
            pin_oe_o    <= nxt_oe;
            pull_en_o   <= nxt_pull;
            dig_in_en_o <= ~analog;
            fn_in_o     <= nxt_fn_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] nxt_rdata;
    logic       nxt_hit;

    always_comb begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            if (sfr_addr_i == data_addr[p]) begin
                nxt_hit   = 1'b1;
                nxt_rdata = sfr_rmw_i ? data_ff[p]
                          : pin_lvl_ff[p*8 +: 8];
            end
            if (sfr_addr_i == OUT_MODE_BASE + 8'(p)) begin
                nxt_hit   = 1'b1;
                nxt_rdata = outmode_ff[p];
            end
        end
        for (int p = 0; p < NPORT - 1; p++) begin
            if (sfr_addr_i == skip_addr[p]) begin
                nxt_hit   = 1'b1;
                nxt_rdata = skip_ff[p];
            end
            if (sfr_addr_i == IN_MODE_BASE + 8'(p)) begin
                nxt_hit   = 1'b1;
                nxt_rdata = inmode_ff[p];
            end
        end
        if (sfr_addr_i == ROUTE0_ADDR) begin
            nxt_hit = 1'b1;
            nxt_rdata = route_ff[0];
        end
        if (sfr_addr_i == ROUTE1_ADDR) begin
            nxt_hit = 1'b1;
            nxt_rdata = route_ff[1];
        end
        if (sfr_addr_i == ROUTE2_ADDR) begin
            nxt_hit = 1'b1;
            nxt_rdata = route_ff[2];
        end
        if (sfr_addr_i == ROUTE3_ADDR) begin
            nxt_hit = 1'b1;
            nxt_rdata = route_ff[3];
        end
        if (sfr_addr_i == PORT4_DATA_ADDR && sfr_bit_i) begin
            nxt_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o   <= 1'b0;
        end else begin
            sfr_rdata_o <= sfr_rd_i ? nxt_rdata : 8'h00;
            sfr_hit_o   <= (sfr_rd_i || sfr_wr_i) && nxt_hit;
        end
    end

endmodule

/* File: pioxb_chk_sva.sv */
// Port-level assertions for the port I/O crossbar block
`timescale 1ns/1ps
module pioxb_chk
    import pioxb_pkg::*;
(
    input wire logic              core_clk_i,   // Clock
    input wire logic              reset_n_i,    // Sync reset, low
    input wire logic              sfr_wr_i,     // Write strobe
    input wire logic              sfr_rd_i,     // Read strobe
    input wire logic              sfr_bit_i,    // Bit access
    input wire logic              sfr_rmw_i,    // Latch read
    input wire logic [7:0]        sfr_addr_i,   // Address
    input wire logic [2:0]        sfr_bitsel_i, // Bit number
    input wire logic [7:0]        sfr_wdata_i,  // Write data
    input wire logic [7:0]        sfr_rdata_o,  // Read data
    input wire logic              sfr_hit_o,    // Decoded
    input wire logic [NPORT*8-1:0] pin_o,       // Drive value
    input wire logic [NPORT*8-1:0] pin_oe_o,    // Driver on
    input wire logic [NPORT*8-1:0] pull_en_o,   // Pull-up on
    input wire logic [NPORT*8-1:0] dig_in_en_o  // Receiver on
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0] p0_ff;
    logic       xbar_ff;

    ////////////////////////////////////////////////////////////////////
    // Shadow of the port 0 latch
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            p0_ff <= DATA_RST;
        end else if (sfr_wr_i && sfr_addr_i == PORT0_DATA_ADDR) begin
            if (sfr_bit_i) begin
                p0_ff[sfr_bitsel_i] <= sfr_wdata_i[0];
            end else begin
                p0_ff <= sfr_wdata_i;
            end
        end
    end

    // Shadow of the crossbar enable bit
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            xbar_ff <= 1'b0;
        end else if (sfr_wr_i && !sfr_bit_i
                     && sfr_addr_i == ROUTE2_ADDR) begin
            xbar_ff <= sfr_wdata_i[XBAR_EN_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////
    oe_off_a: assert property (!$past(xbar_ff) |-> pin_oe_o == '0)
        else $error("driver on while crossbar off");
    reset_state_a: assert property ($rose(reset_n_i) |->
        pull_en_o == '1 && dig_in_en_o == '1 && pin_oe_o == '0)
        else $error("bad state after reset");
    rmw_latch_a: assert property (sfr_rd_i && sfr_rmw_i && !sfr_bit_i
        && sfr_addr_i == PORT0_DATA_ADDR |=> sfr_rdata_o == $past(p0_ff))
        else $error("latch read mismatch");
    analog_pin_a: assert property (
        (~dig_in_en_o & (pull_en_o | pin_oe_o)) == '0)
        else $error("analog pin still pulled or driven");
    port4_dig_a: assert property (dig_in_en_o[39:32] == 8'hFF)
        else $error("port 4 receiver off");
    low_pull_a: assert property ((pin_oe_o & ~pin_o & pull_en_o) == '0)
        else $error("pull-up on while driving low");
    hit_decode_a: assert property (sfr_rd_i && sfr_addr_i ==
        PORT0_DATA_ADDR |=> sfr_hit_o)
        else $error("port 0 read not decoded");
    idle_rdata_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
        else $error("read data without read");
    unmapped_a: assert property (sfr_rd_i && sfr_addr_i == 8'h00
        |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("unmapped address answered");
    rmw_c: cover property (sfr_rd_i && sfr_rmw_i);
    analog_c: cover property (!dig_in_en_o[0]);
    unmapped_c: cover property (sfr_rd_i && sfr_addr_i == 8'h00);
    xbar_on_c: cover property (pin_oe_o != '0);
endmodule

bind pioxb_top pioxb_chk u_chk (.core_clk_i, .reset_n_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_bit_i, .sfr_rmw_i, .sfr_addr_i, .sfr_bitsel_i,
    .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .pin_o, .pin_oe_o,
    .pull_en_o, .dig_in_en_o);

/* File: pioxb_pins.sv */
// Model of the package pins outside the port block
`timescale 1ns/1ps
module pioxb_pins (
    input  wire logic        clk_i,     // Clock
    input  wire logic [39:0] drv_i,     // Block drive value
    input  wire logic [39:0] oe_i,      // Block driver on
    input  wire logic [39:0] pull_i,    // Weak pull-up on
    input  wire logic [39:0] ext_en_i,  // Outside drives pin
    input  wire logic [39:0] ext_val_i, // Outside value
    output logic      [39:0] lvl_o      // Resolved pin level
);
    logic [39:0] tgl_ff = 40'h55AA55AA55;

    // Undriven, unpulled pins wander every cycle
    always_ff @(posedge clk_i) begin
        tgl_ff <= ~tgl_ff;
    end

    always_comb begin
        for (int i = 0; i < 40; i++) begin
            lvl_o[i] = oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] :
                       pull_i[i] ? 1'b1 : tgl_ff[i];
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the port I/O crossbar block
`timescale 1ns/1ps
module testbench;
    import pioxb_pkg::*;
    logic        core_clk_i;
    logic        reset_n_i;
    logic        wr, rd, bacc, rmw, hit;
    logic [7:0]  addr, wdata, rdata;
    logic [2:0]  bsel;
    logic [7:0]  fn_in, fn_out;
    logic [39:0] lvl, pdrv, oe, pull, dig, ext_en, ext_val;
    int          miscompares, checks;

    pioxb_top u_pioxb_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_bit_i(bacc), .sfr_rmw_i(rmw),
        .sfr_addr_i(addr), .sfr_bitsel_i(bsel), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .fn_out_i(fn_out),
        .fn_in_o(fn_in), .pin_i(lvl), .pin_o(pdrv), .pin_oe_o(oe),
        .pull_en_o(pull), .dig_in_en_o(dig));
    pioxb_pins u_pioxb_pins (.clk_i(core_clk_i), .drv_i(pdrv), .oe_i(oe),
        .pull_i(pull), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(lvl));

    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string nm, input logic [39:0] s, e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, d, input logic b = 0,
                          input logic [2:0] s = 0);
        @(negedge core_clk_i);
        {wr, addr, wdata, bacc, bsel} = {1'b1, a, d, b, s};
        @(negedge core_clk_i);
        {wr, bacc} = 2'b00;
    endtask

    // Read, then compare data and decode flag
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic r, input logic [7:0] e,
                        input logic eh = 1);
        @(negedge core_clk_i);
        {rd, addr, rmw} = {1'b1, a, r};
        @(negedge core_clk_i);
        check(nm, {32'h0, rdata}, {32'h0, e});
        check({nm, "_hit"}, {39'h0, hit}, {39'h0, eh});
        {rd, rmw} = 2'b00;
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {wr, rd, bacc, rmw, addr, wdata, bsel} = '0;
        {ext_en, ext_val} = '0;
        fn_out = 8'h00;
        miscompares = 0;
        checks = 0;
        reset_n_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        check("oe_rst", oe, 40'h0);
        check("dig_rst", dig, {40{1'b1}});
        check("pull_od", pull, {40{1'b1}});
        rchk("p0_rst", PORT0_DATA_ADDR, 1, DATA_RST);
        rchk("p3_rst", PORT3_DATA_ADDR, 1, DATA_RST);
        rchk("skip_rst", PORT2_SKIP_ADDR, 0, SKIP_RST);
        wr_reg(PORT2_SKIP_ADDR, 8'hA5);
        rchk("skip_rw", PORT2_SKIP_ADDR, 0, 8'hA5);
        wr_reg(PORT0_DATA_ADDR, 8'h5A);
        rchk("p0_latch", PORT0_DATA_ADDR, 1, 8'h5A);
        ext_en[7:0] = 8'hFF;
        ext_val[7:0] = 8'hC3;
        repeat (6) @(negedge core_clk_i);
        rchk("p0_pins", PORT0_DATA_ADDR, 0, 8'hC3);
        rchk("p0_rmw", PORT0_DATA_ADDR, 1, 8'h5A);
        wr_reg(PORT0_DATA_ADDR, 8'h01, 1, 3'd0);
        wr_reg(PORT0_DATA_ADDR, 8'h00, 1, 3'd6);
        rchk("p0_bit", PORT0_DATA_ADDR, 1, 8'h1B);
        wr_reg(PORT3_DATA_ADDR, 8'h00, 1, 3'd7);
        rchk("p3_bit", PORT3_DATA_ADDR, 1, 8'h7F);
        wr_reg(PORT4_DATA_ADDR, 8'h12);
        wr_reg(PORT4_DATA_ADDR, 8'h01, 1, 3'd0);
        rchk("p4_byte", PORT4_DATA_ADDR, 1, 8'h12);
        rchk("unmapped", 8'h00, 0, 8'h00, 0);
        wr_reg(IN_MODE_BASE, 8'hFE);
        wr_reg(IN_MODE_BASE + 8'h04, 8'h00);
        @(negedge core_clk_i);
        check("analog_rx", {39'h0, dig[0]}, 40'h0);
        check("analog_pu", {39'h0, pull[0]}, 40'h0);
        check("digital_rx", {33'h0, dig[7:1]}, {33'h0, 7'h7F});
        check("p4_digital", {32'h0, dig[39:32]}, {32'h0, 8'hFF});
        wr_reg(OUT_MODE_BASE, 8'hFF);
        wr_reg(OUT_MODE_BASE + 8'h02, 8'h0F);
        wr_reg(PORT0_SKIP_ADDR, 8'h01);
        wr_reg(ROUTE0_ADDR, 8'h03);
        wr_reg(PORT1_DATA_ADDR, 8'h00);
        repeat (2) @(negedge core_clk_i);
        check("oe_no_xbar", oe, 40'h0);
        check("pull_low", pull[15:8] & ~pdrv[15:8] & oe[15:8], 40'h0);
        fn_out = 8'h02;
        ext_val[7:0] = 8'hC7;
        wr_reg(ROUTE2_ADDR, 8'h40);
        repeat (6) @(negedge core_clk_i);
        check("oe_p0", {32'h0, oe[7:0]}, {32'h0, 8'hFA});
        check("pull_p0", {32'h0, pull[7:0]}, {32'h0, 8'h04});
        check("drv_p0", {32'h0, pdrv[7:0]}, {32'h0, 8'h1D});
        check("oe_p1", {32'h0, oe[15:8]}, {32'h0, 8'hFF});
        check("pull_p1", {32'h0, pull[15:8]}, 40'h0);
        check("oe_p2", {32'h0, oe[23:16]}, {32'h0, 8'h0F});
        check("pull_p2", {32'h0, pull[23:16]}, {32'h0, 8'hF0});
        check("oe_p4", {32'h0, oe[39:32]}, {32'h0, 8'hED});
        check("fn_in", {32'h0, fn_in}, {32'h0, 8'hFE});
        rchk("xbar_rd", ROUTE2_ADDR, 0, 8'h40);
        wr_reg(ROUTE2_ADDR, 8'hC0);
        @(negedge core_clk_i);
        check("pull_off", {32'h0, pull[23:16]}, 40'h0);
        end_of_test;
    end
endmodule
